// >>> verilog/sadec_pkg.sv
package sadec_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_LOW_TOP    = 8'h00;
    localparam logic [7:0] OFS_RECL_BASE  = 8'h04;
    localparam logic [7:0] OFS_RECL_LIM   = 8'h08;
    localparam logic [7:0] OFS_EGRESS     = 8'h0C;
    localparam logic [7:0] OFS_HUB        = 8'h10;
    localparam logic [7:0] OFS_LINKWIN    = 8'h14;
    localparam logic [7:0] OFS_FLATCFG    = 8'h18;
    localparam logic [7:0] OFS_GFX_MMIO   = 8'h1C;
    localparam logic [7:0] OFS_GFX_APER   = 8'h20;
    localparam logic [7:0] OFS_GFX_TT     = 8'h24;
    localparam logic [7:0] OFS_GFX_IO     = 8'h28;
    localparam logic [7:0] OFS_GFXCTL     = 8'h2C;
    localparam logic [7:0] OFS_LEGACY     = 8'h30;
    localparam logic [7:0] OFS_SEG_ATTR   = 8'h34;
    localparam logic [7:0] OFS_TT_BASE    = 8'hA8;
    localparam logic [7:0] OFS_STATUS     = 8'h38;

    // Address map constants.
    localparam logic [31:0] DRAM_CAP      = 32'h8000_0000;
    localparam logic [31:0] DOS_TOP       = 32'h000A_0000;
    localparam logic [31:0] VIDEO_TOP     = 32'h000C_0000;
    localparam logic [31:0] MONO_BASE     = 32'h000B_0000;
    localparam logic [31:0] MONO_TOP      = 32'h000B_8000;
    localparam logic [31:0] EXP_TOP       = 32'h000E_0000;
    localparam logic [31:0] EXTB_TOP      = 32'h000F_0000;
    localparam logic [31:0] LEGACY_TOP    = 32'h0010_0000;
    localparam int          SEG_SHIFT     = 14;
    localparam logic [16:0] IO_SPACE_TOP  = 17'h1_0003;

    // Window size masks (inverted span).
    localparam logic [31:0] MASK_4K       = 32'hFFFF_F000;
    localparam logic [31:0] MASK_16K      = 32'hFFFF_C000;
    localparam logic [31:0] MASK_512K     = 32'hFFF8_0000;
    localparam logic [31:0] MASK_1M       = 32'hFFF0_0000;
    localparam logic [31:0] MASK_64M      = 32'hFC00_0000;
    localparam logic [31:0] MASK_128M     = 32'hF800_0000;
    localparam logic [31:0] MASK_256M     = 32'hF000_0000;
    localparam logic [31:0] MASK_512M     = 32'hE000_0000;
    localparam logic [15:0] IO_PAIR_MASK  = 16'hFFF8;

    // Reset values.
    localparam logic [31:0] RST_LOW_TOP   = 32'h0800_0000;
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [1:0]  ATTR_OFF      = 2'h0;

    // Control field positions.
    localparam int GC_STOLEN_LSB = 0;    // Graphics stolen select, 3 bits.
    localparam int GC_TT_LSB     = 4;    // Translation table stolen size, 2 bits.
    localparam int GC_APER_LSB   = 8;    // Aperture size select, 2 bits.
    localparam int GC_CFG_LSB    = 12;   // Flat config size select, 2 bits.
    localparam int GC_GFX_EN     = 16;   // Integrated graphics enabled.
    localparam int GC_GFX_VGA    = 17;   // Integrated graphics is VGA device.
    localparam int LG_VGA_EN     = 0;    // Express port VGA enable.
    localparam int LG_MONO_PRES  = 1;    // Monochrome present bit.
    localparam int LG_MANAGEMENT_RAM_EN   = 2;    // Compatible management RAM enable.
    localparam int LG_MONO_GFX   = 3;    // Monochrome steered to graphics.

    // Destinations, one-hot.
    typedef enum logic [4:0] {
        SADEC_DST_DRAM  = 5'b00001,
        SADEC_DST_GFX   = 5'b00010,
        SADEC_DST_PCIE  = 5'b00100,
        SADEC_DST_LINK  = 5'b01000,
        SADEC_DST_HUB   = 5'b10000
    } sadec_dst_e;

    // Initiators.
    typedef enum logic [2:0] {
        SADEC_SRC_CPU   = 3'b001,
        SADEC_SRC_PCIE  = 3'b010,
        SADEC_SRC_LINK  = 3'b100
    } sadec_src_e;

    // One routing request.
    typedef struct packed {
        logic        valid;
        sadec_src_e  src;
        logic        is_io;
        logic        write;
        logic        snoop;
        logic        mgmt_mode;
        logic        tiled;
        logic [35:0] addr;
    } sadec_req_s;

    // One routing answer.
    typedef struct packed {
        logic        valid;
        sadec_dst_e  dst;
        logic        reject;
        logic        peer;
        logic [31:0] phys;
    } sadec_rsp_s;

endpackage

// >>> verilog/sadec_top.sv
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sadec_top (
    input  wire logic                  core_clk_i,   // Core clock.
    input  wire logic                  resetn_i,     // Async reset, low.
    input  wire logic                  hsel_i,       // Slave select.
    input  wire logic [31:0]           haddr_i,      // Bus address.
    input  wire logic [1:0]            htrans_i,     // Transfer type.
    input  wire logic                  hwrite_i,     // Write strobe.
    input  wire logic [2:0]            hsize_i,      // Transfer size.
    input  wire logic [31:0]           hwdata_i,     // Write data.
    input  wire logic                  hready_i,     // Bus ready.
    output logic [31:0]                hrdata_o,     // Read data.
    output logic                       hreadyout_o,  // Slave ready.
    output logic                       hresp_o,      // Always OKAY.
    input  wire sadec_pkg::sadec_req_s req_i,        // Routing request.
    output sadec_pkg::sadec_rsp_s      rsp_o         // Routing answer.
);
    import sadec_pkg::*;

    // Software state.
    logic [31:0] low_top_r, recl_base_r, recl_lim_r;
    logic [31:0] egress_r, hub_r, linkwin_r, flatcfg_r;
    logic [31:0] gmmio_r, gaper_r, gtt_r, gio_r, gfxctl_r, legacy_r, seg_attr_r;
    logic [31:0] tt_base_r;
    logic [31:0] status_r;
    logic        wr_pend_r;
    logic [7:0]  wr_ofs_r;

    // Bus decode: a write's address is kept for its data phase.
    wire        bus_go  = hsel_i & hready_i & htrans_i[1];
    wire        bus_wr  = bus_go & hwrite_i;
    wire        wr_en   = wr_pend_r;

    // The slave never stalls and never errors.
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 8'h00;
        end
        else
        begin
            wr_pend_r <= bus_wr;
            wr_ofs_r  <= haddr_i[7:0];
        end
    end

    // Aligned windows keep their low bits at zero.
    function automatic logic [31:0] align(input logic [31:0] v, input logic [31:0] m);
        align = v & m;
    endfunction

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            low_top_r   <= RST_LOW_TOP;
            recl_base_r <= RST_ZERO;
            recl_lim_r  <= RST_ZERO;
            egress_r    <= RST_ZERO;
            hub_r       <= RST_ZERO;
            linkwin_r   <= RST_ZERO;
            flatcfg_r   <= RST_ZERO;
            gmmio_r     <= RST_ZERO;
            gaper_r     <= RST_ZERO;
            gtt_r       <= RST_ZERO;
            gio_r       <= RST_ZERO;
            gfxctl_r    <= RST_ZERO;
            legacy_r    <= RST_ZERO;
            seg_attr_r  <= RST_ZERO;     // All segments disabled.
            tt_base_r   <= RST_ZERO;
        end
        else if (wr_en)
        begin
            case (wr_ofs_r)
                OFS_LOW_TOP:   low_top_r   <= align(hwdata_i, MASK_1M);
                OFS_RECL_BASE: recl_base_r <= align(hwdata_i, MASK_1M);
                OFS_RECL_LIM:  recl_lim_r  <= align(hwdata_i, MASK_1M);
                OFS_EGRESS:    egress_r    <= {align(hwdata_i, MASK_4K) | {31'h0, hwdata_i[0]}};
                OFS_HUB:       hub_r       <= {align(hwdata_i, MASK_16K) | {31'h0, hwdata_i[0]}};
                OFS_LINKWIN:   linkwin_r   <= {align(hwdata_i, MASK_4K) | {31'h0, hwdata_i[0]}};
                OFS_FLATCFG:   flatcfg_r   <= {align(hwdata_i, MASK_64M) | {31'h0, hwdata_i[0]}};
                OFS_GFX_MMIO:  gmmio_r     <= align(hwdata_i, MASK_512K);
                OFS_GFX_APER:  gaper_r     <= align(hwdata_i, MASK_128M);
                OFS_GFX_TT:    gtt_r       <= align(hwdata_i, MASK_1M);
                OFS_GFX_IO:    gio_r       <= {16'h0000, hwdata_i[15:0] & IO_PAIR_MASK};
                OFS_GFXCTL:    gfxctl_r    <= hwdata_i;
                OFS_LEGACY:    legacy_r    <= hwdata_i;
                OFS_SEG_ATTR:  seg_attr_r  <= hwdata_i;
                OFS_TT_BASE:   tt_base_r   <= align(hwdata_i, MASK_1M);
                default:       ;
            endcase
        end
    end

    // Reads answer from the address phase; unmapped offsets read zero.
    logic [31:0] rd_mux;
    always_comb
    begin
        case (haddr_i[7:0])
            OFS_LOW_TOP:   rd_mux = low_top_r;
            OFS_RECL_BASE: rd_mux = recl_base_r;
            OFS_RECL_LIM:  rd_mux = recl_lim_r;
            OFS_EGRESS:    rd_mux = egress_r;
            OFS_HUB:       rd_mux = hub_r;
            OFS_LINKWIN:   rd_mux = linkwin_r;
            OFS_FLATCFG:   rd_mux = flatcfg_r;
            OFS_GFX_MMIO:  rd_mux = gmmio_r;
            OFS_GFX_APER:  rd_mux = gaper_r;
            OFS_GFX_TT:    rd_mux = gtt_r;
            OFS_GFX_IO:    rd_mux = gio_r;
            OFS_GFXCTL:    rd_mux = gfxctl_r;
            OFS_LEGACY:    rd_mux = legacy_r;
            OFS_SEG_ATTR:  rd_mux = seg_attr_r;
            OFS_TT_BASE:   rd_mux = tt_base_r;
            OFS_STATUS:    rd_mux = status_r;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hrdata_o <= 32'h0000_0000;
        else if (bus_go && !hwrite_i)
            hrdata_o <= rd_mux;
    end

    // Request field views.
    wire [35:0] a36     = req_i.addr;
    wire [31:0] a       = a36[31:0];
    wire        above4g = |a36[35:32];
    wire        from_cpu  = req_i.src == SADEC_SRC_CPU;
    wire        from_link = req_i.src == SADEC_SRC_LINK;
    wire        from_peer = !from_cpu;
    wire        gfx_en  = gfxctl_r[GC_GFX_EN];
    wire        gfx_vga = gfxctl_r[GC_GFX_VGA] & gfx_en;
    wire        vga_en  = legacy_r[LG_VGA_EN];
    wire        mono_p  = legacy_r[LG_MONO_PRES];

    // Size selects for the variable windows.
    wire [1:0]  aper_sel = gfxctl_r[GC_APER_LSB +: 2];
    wire [1:0]  cfg_sel  = gfxctl_r[GC_CFG_LSB +: 2];
    wire [31:0] aper_m   = (aper_sel == 2'h2) ? MASK_512M :
                           (aper_sel == 2'h1) ? MASK_256M : MASK_128M;
    wire [31:0] cfg_m    = (cfg_sel == 2'h2) ? MASK_256M :
                           (cfg_sel == 2'h1) ? MASK_128M : MASK_64M;

    // Stolen memory sits just below the low DRAM top.
    wire [2:0]  gms      = gfxctl_r[GC_STOLEN_LSB +: 3];
    wire [1:0]  ggms     = gfxctl_r[GC_TT_LSB +: 2];
    wire [31:0] gms_sz   = (gms == 3'h0) ? 32'h0 : (32'h0010_0000 << (gms - 3'h1));
    wire [31:0] ggms_sz  = {10'h000, ggms, 20'h0_0000};
    wire [31:0] stolen_lo = low_top_r - gms_sz - ggms_sz;
    wire        in_stolen = gfx_en && a >= stolen_lo && a < low_top_r;

    // Window hit helper used by every programmable window except the reclaim range and the I/O pair.
    function automatic logic win_hit(input logic [31:0] adr, input logic [31:0] base,
                                     input logic [31:0] m, input logic en);
        win_hit = en && ((adr & m) == (base & m));
    endfunction

    // Programmable windows.
    wire hit_egr  = win_hit(a, egress_r,  MASK_4K,   egress_r[0]);
    wire hit_hub  = win_hit(a, hub_r,     MASK_16K,  hub_r[0]);
    wire hit_lwin = win_hit(a, linkwin_r, MASK_4K,   linkwin_r[0]);
    wire hit_cfg  = win_hit(a, flatcfg_r, cfg_m,     flatcfg_r[0]);
    wire hit_gmm  = win_hit(a, gmmio_r,   MASK_512K, gfx_en);
    wire hit_gap  = win_hit(a, gaper_r,   aper_m,    gfx_en);
    wire hit_gtt  = win_hit(a, gtt_r,     MASK_1M,   gfx_en);
    wire hit_hubw = hit_egr | hit_hub | hit_lwin | hit_cfg;
    wire hit_gfxw = hit_gmm | hit_gap | hit_gtt;

    // Legacy regions and their 16 KB segment index.
    wire in_dos   = a < DOS_TOP;
    wire in_video = a >= DOS_TOP && a < VIDEO_TOP;
    wire in_mono  = a >= MONO_BASE && a < MONO_TOP;
    wire in_attr  = a >= VIDEO_TOP && a < LEGACY_TOP;
    wire [3:0] seg = 4'((a - VIDEO_TOP) >> SEG_SHIFT);
    // Segments 0..7 expansion, 8..11 extended BIOS, 12..15 share the top BIOS field.
    wire [3:0] fld = (seg > 4'hB) ? 4'hC : seg;
    wire [1:0] attr = (fld == 4'hC) ? seg_attr_r[31:30] : seg_attr_r[2*fld +: 2];
    wire attr_ok  = req_i.write ? attr[1] : attr[0];

    // Main DRAM below the low top and the 2 GB cap.
    wire in_main  = !above4g && a >= LEGACY_TOP && a < low_top_r && a < DRAM_CAP;
    // Reclaim window above 4G.
    wire in_recl  = above4g && a36[35:20] >= {4'h0, recl_base_r[31:20]} + 16'h1000
                    && a36[35:20] < {4'h0, recl_lim_r[31:20]} + 16'h1000;
    wire [31:0] recl_phys = a - recl_base_r;

    // Video destination chosen by steering bits.
    wire [4:0] vga_dst = gfx_vga ? SADEC_DST_GFX : vga_en ? SADEC_DST_PCIE : SADEC_DST_LINK;
    wire [4:0] mono_dst = (gfx_vga && legacy_r[LG_MONO_GFX]) ? SADEC_DST_GFX :
                          mono_p ? SADEC_DST_LINK : vga_dst;

    // I/O decode.
    wire [15:0] io = a[15:0];
    // The I/O space runs three bytes past 64 KB, so bit 16 alone is not a refusal.
    wire io_ok   = a[31:17] == 15'h0000 && a[16:0] < IO_SPACE_TOP;
    wire io_pair = gfx_en && (io & IO_PAIR_MASK) == gio_r[15:0];
    wire io_mono = io == 16'h03B4 || io == 16'h03B5 || io == 16'h03B8 ||
                   io == 16'h03B9 || io == 16'h03BA || io == 16'h03BF;

    logic [4:0]  dst;
    logic        rej;
    logic        peer;
    logic [31:0] phys;
    always_comb
    begin
        dst  = SADEC_DST_LINK;
        rej  = 1'b0;
        peer = 1'b0;
        phys = a;
        if (req_i.is_io)
        begin
            if (!io_ok)
                rej = 1'b1;
            else if (io_pair)
                dst = SADEC_DST_GFX;
            else if (io_mono)
                dst = mono_dst;
        end
        else if (above4g)
        begin
            if (in_recl && recl_phys < DRAM_CAP)
            begin
                dst  = SADEC_DST_DRAM;
                phys = recl_phys;
            end
        end
        else if (in_dos)
            dst = SADEC_DST_DRAM;
        else if (in_video)
        begin
            if (legacy_r[LG_MANAGEMENT_RAM_EN] && from_cpu && req_i.mgmt_mode)
                dst = SADEC_DST_DRAM;
            else if (from_link && gfx_vga)
                rej = 1'b1;
            else
            begin
                dst  = in_mono ? mono_dst : vga_dst;
                peer = from_peer && legacy_r[LG_MANAGEMENT_RAM_EN] && !gfx_vga;
            end
        end
        else if (in_attr)
        begin
            if (from_peer && !req_i.snoop)
                dst = SADEC_DST_DRAM;
            else if (attr_ok)
                dst = SADEC_DST_DRAM;
        end
        else if (in_main && !in_stolen)
            dst = SADEC_DST_DRAM;                     // memory beats windows.
        else if (a >= low_top_r && hit_hubw)
            dst = SADEC_DST_HUB;
        else if (a >= low_top_r && hit_gfxw)
        begin
            dst = SADEC_DST_GFX;
            if (from_link && hit_gap && (!req_i.write || req_i.tiled))
                rej = 1'b1;
        end
    end

    // Registered answer, one cycle after the request.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rsp_o    <= '0;
            status_r <= RST_ZERO;
        end
        else
        begin
            rsp_o.valid  <= req_i.valid;
            rsp_o.dst    <= sadec_dst_e'(dst);
            rsp_o.reject <= rej;
            rsp_o.peer   <= peer;
            rsp_o.phys   <= phys;
            if (req_i.valid)
                status_r <= {22'h0, rej, peer, 3'h0, dst};
        end
    end

    // Assertions.
    property p_cap;
        @(posedge core_clk_i) disable iff (!resetn_i)
        rsp_o.valid && rsp_o.dst == SADEC_DST_DRAM |-> rsp_o.phys < DRAM_CAP;
    endproperty
    a_cap: assert property (p_cap) else $error("DRAM access above cap.");

    property p_dos;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && in_dos
        |=> rsp_o.dst == SADEC_DST_DRAM && !rsp_o.reject;
    endproperty
    a_dos: assert property (p_dos) else $error("Low 640K not sent to DRAM.");

    property p_aper;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && a >= LEGACY_TOP && from_link
        && !req_i.write && hit_gap && a >= low_top_r && !hit_hubw |=> rsp_o.reject;
    endproperty
    a_aper: assert property (p_aper) else $error("Link aperture read accepted.");

    property p_mgmt;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && in_video && from_cpu
        && req_i.mgmt_mode && legacy_r[LG_MANAGEMENT_RAM_EN] |=> rsp_o.dst == SADEC_DST_DRAM;
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("Management access not in DRAM.");

    property p_peer_vga;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && in_video && from_link
        |=> rsp_o.dst != SADEC_DST_GFX;
    endproperty
    a_peer_vga: assert property (p_peer_vga) else $error("Link peer to graphics VGA.");

    property p_nosnoop;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && in_attr && from_peer && !req_i.snoop
        |=> rsp_o.dst == SADEC_DST_DRAM;
    endproperty
    a_nosnoop: assert property (p_nosnoop) else $error("Non-snooped legacy not DRAM.");

    property p_attr;
        @(posedge core_clk_i) disable iff (!resetn_i)
        req_i.valid && !req_i.is_io && !above4g && in_attr && from_cpu && !attr_ok
        |=> rsp_o.dst == SADEC_DST_LINK;
    endproperty
    a_attr: assert property (p_attr) else $error("Disabled segment hit DRAM.");

    property p_reset_bios;
        @(posedge core_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> seg_attr_r[31:30] == ATTR_OFF;
    endproperty
    a_reset_bios: assert property (p_reset_bios) else $error("BIOS segment not disabled.");

    c_dram: cover property (@(posedge core_clk_i) rsp_o.valid && rsp_o.dst == SADEC_DST_DRAM);
    c_hub:  cover property (@(posedge core_clk_i) rsp_o.valid && rsp_o.dst == SADEC_DST_HUB);
    c_peer: cover property (@(posedge core_clk_i) rsp_o.valid && rsp_o.peer);
    c_rej:  cover property (@(posedge core_clk_i) rsp_o.valid && rsp_o.reject);

endmodule
`default_nettype wire

// >>> verif/sadec_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Requester model for the CPU, express and chipset link side of the decoder.
module sadec_far_model
    import sadec_pkg::*;
(
    input  wire logic                 clk_i,  // Core clock.
    output var  sadec_pkg::sadec_req_s req_o  // Request to the decoder.
);
    initial req_o = '0;
    // A request stands one cycle, since the decoder samples it at every edge.
    // Flags are {is_io, write, snoop, mgmt_mode}; tiled writes are never made.
    task automatic issue(input sadec_src_e s, input logic [3:0] f, input logic [35:0] a);
        @(posedge clk_i);
        req_o <= {1'b1, s, f, 1'b0, a};
        @(posedge clk_i);
        req_o.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/system_address_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module system_address_decoder_tb_top;
    import sadec_pkg::*;
    logic        clk, rstn, hsel, hwrite, hrdy, rd_v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd_d, lfsr;
    sadec_req_s  req;
    sadec_rsp_s  rsp;
    int          n_errors, checked;
    logic [31:0] dq[$];
    logic [5:0]  rq[$], e;
    logic [32:0] pq[$];
    localparam logic [5:0] DR = {1'b0, SADEC_DST_DRAM}, LK = {1'b0, SADEC_DST_LINK};
    localparam logic [5:0] PC = {1'b0, SADEC_DST_PCIE}, HB = {1'b0, SADEC_DST_HUB};
    localparam logic [5:0] RJ = 6'h20;
    localparam logic [5:0] GX = {1'b0, SADEC_DST_GFX};

    sadec_top dut (.core_clk_i(clk), .resetn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .req_i(req),
        .rsp_o(rsp));
    sadec_far_model far (.clk_i(clk), .req_o(req));

    // Free-running core clock at 250 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk_rd(input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x)
        begin
            n_errors++;
            $display("mismatch hrdata exp %h got %h", x, g);
        end
    endtask

    task automatic chk_rt(input logic [5:0] x, input logic [5:0] g);
        checked++;
        if (g !== x)
        begin
            n_errors++;
            $display("mismatch route exp %h got %h", x, g);
        end
    endtask

    // Peer flag and physical address, as {peer, phys}.
    task automatic chk_ph(input logic [32:0] x, input logic [32:0] g);
        checked++;
        if (g !== x)
        begin
            n_errors++;
            $display("mismatch phys exp %h got %h", x, g);
        end
    endtask

    // One whole-word transfer; the address phase is held until ready is seen.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsel <= 1'b1; hsize <= 3'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        if (!w) rd_d <= hrdata;
        if (!w) rd_v <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        dq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic rtp(input sadec_src_e s, input logic [3:0] f, input logic [35:0] a,
                       input logic [5:0] x, input logic [32:0] p);
        rq.push_back(x);
        pq.push_back(p);
        far.issue(s, f, a);
    endtask

    // Untranslated cycles carry their own low address and no peer flag.
    task automatic rt(input sadec_src_e s, input logic [3:0] f, input logic [35:0] a,
                      input logic [5:0] x);
        rtp(s, f, a, x, {1'b0, a[31:0]});
    endtask

    task automatic complete_run();
        if (rq.size() != 0) n_errors++;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Results are matched against the oldest note as soon as they appear.
    always @(posedge clk)
    begin
        if (rd_v === 1'b1) rd_v <= 1'b0;
        if (rd_v === 1'b1 && dq.size() > 0) chk_rd(dq.pop_front(), rd_d);
        if (rsp.valid === 1'b1)
        begin
            e = (rq.size() > 0) ? rq.pop_front() : 6'h3F;
            if (e == RJ) chk_rt(RJ, {rsp.reject, 5'h0});
            else chk_rt(e, {rsp.reject, rsp.dst});
            chk_ph((pq.size() > 0) ? pq.pop_front() : 33'h0, {rsp.peer, rsp.phys});
        end
    end

    // Cuts a hang short at 10000 cycles, well beyond the roughly 130 cycles the tests need.
    initial
    begin
        #40000;
        n_errors++;
        complete_run();
    end

    // Main sequence; the egress window is placed inside main DRAM once, and graphics MMIO and table windows both stay at zero.
    initial
    begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata, rd_v, rd_d} = '0;
        n_errors = 0; checked = 0; lfsr = 32'h47E2A876; rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(OFS_LOW_TOP, RST_LOW_TOP);
        rd(OFS_SEG_ATTR, RST_ZERO);
        rd(8'h3C, RST_ZERO);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000F_0000, LK);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000C_0000, LK);
        rt(SADEC_SRC_PCIE, 4'h0, 36'h0_000C_4000, DR);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_0800_0000, LK);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_07FF_FFFC, DR);
        rt(SADEC_SRC_LINK, 4'hA, 36'h0_0001_0003, RJ);
        rt(SADEC_SRC_LINK, 4'hA, 36'h0_0001_0002, LK);
        rt(SADEC_SRC_LINK, 4'hA, 36'h0_0000_FFFF, LK);
        repeat (8)
        begin
            lfsr = lfsr_nxt(lfsr);
            rt(SADEC_SRC_CPU, {1'b0, lfsr[20], 2'h2}, {16'h0, lfsr[19:0] % 20'hA0000}, DR);
        end
        bus(1'b1, OFS_SEG_ATTR, 32'hC003_0001);
        rd(OFS_SEG_ATTR, 32'hC003_0001);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000C_0000, DR);
        rt(SADEC_SRC_CPU, 4'h6, 36'h0_000C_0000, LK);
        rt(SADEC_SRC_CPU, 4'h6, 36'h0_000C_4000, LK);
        rt(SADEC_SRC_CPU, 4'h6, 36'h0_000E_0000, DR);
        rt(SADEC_SRC_CPU, 4'h6, 36'h0_000E_4000, LK);
        rt(SADEC_SRC_CPU, 4'h6, 36'h0_000F_8000, DR);
        bus(1'b1, OFS_LOW_TOP, 32'hC000_0000);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_7FFF_0000, DR);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_9000_0000, LK);
        bus(1'b1, OFS_EGRESS, 32'hE000_0001);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_E000_0800, HB);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_E000_1000, LK);
        bus(1'b1, OFS_EGRESS, 32'h0010_0001);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_0010_0800, DR);
        bus(1'b1, OFS_LEGACY, 32'h0000_0004);
        rt(SADEC_SRC_CPU, 4'h3, 36'h0_000A_0000, DR);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000A_0000, LK);
        bus(1'b1, OFS_LEGACY, 32'h0000_0005);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000B_8000, PC);
        rtp(SADEC_SRC_PCIE, 4'h2, 36'h0_000A_0000, PC, {1'b1, 32'h000A_0000});
        bus(1'b1, OFS_RECL_BASE, 32'h0010_0000);
        bus(1'b1, OFS_RECL_LIM, 32'h0020_0000);
        rtp(SADEC_SRC_CPU, 4'h2, 36'h1_0010_0000, DR, 33'h0);
        rt(SADEC_SRC_CPU, 4'h2, 36'h1_0030_0000, LK);
        bus(1'b1, OFS_GFXCTL, 32'h0003_0000);
        bus(1'b1, OFS_GFX_APER, 32'hD000_0000);
        rt(SADEC_SRC_LINK, 4'h2, 36'h0_000A_0000, RJ);
        rt(SADEC_SRC_CPU, 4'h2, 36'h0_000A_0000, GX);
        rt(SADEC_SRC_LINK, 4'h2, 36'h0_D000_0000, RJ);
        rt(SADEC_SRC_LINK, 4'h6, 36'h0_D000_0000, GX);
        rd(OFS_STATUS, {27'h0, SADEC_DST_GFX});
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
